/* File: core/emb_params.svh */
// Constants of the external memory bus sequencer
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
// ========================================
// Register byte offsets
`define EMB_OFS_CTRL 12'h000
`define EMB_OFS_PAD 12'h004
`define EMB_OFS_PMD 12'h008
`define EMB_OFS_STAT 12'h00c
// ========================================
// Field positions
`define EMB_CTRL_DIS_BIT 7
`define EMB_CTRL_WAIT_HI 5
`define EMB_CTRL_WAIT_LO 4
`define EMB_CTRL_WM_HI 1
`define EMB_CTRL_WM_LO 0
`define EMB_PAD_PU_HI 7
`define EMB_PAD_PU_LO 5
`define EMB_PMD_BUS_BIT 0
// ========================================
// Writable masks and reset values
`define EMB_CTRL_WMASK 8'hb3
`define EMB_CTRL_RESET 8'h30
`define EMB_PAD_WMASK 8'he6
`define EMB_PAD_RESET 8'h00
`define EMB_PMD_RESET 8'h00
// ========================================
// Write mode codes and timing
`define EMB_WM_BYTE_WRITE 2'b00
`define EMB_WM_BYTE_SELECT 2'b01
`define EMB_TICKS_PER_TCY 4'h4
`endif

/* File: core/emb_pkg.sv */
// Types of the external memory bus sequencer
package emb_pkg;
  // ========================================
  // Access kinds and sequencer states
  typedef enum logic [1:0] {EMB_FETCH, EMB_TABLE_READ, EMB_TABLE_WRITE_OP} emb_kind_t;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_DATA2, ST_END, ST_WAIT} emb_state_t;
  // ========================================
  // Core request
  typedef struct packed {
    emb_kind_t kind;
    logic [20:0] table_pointer;
    logic [7:0] table_latch_reg;
  } emb_req_t;
  // ========================================
  // Bus pins
  typedef struct packed {
    logic [15:0] ad_out;
    logic [1:0] ad_oe;
    logic [3:0] addr_upper;
    logic ale;
    logic oe_n;
    logic ce_n;
    logic write_high_strobe_n;
    logic write_low_strobe_n;
    logic byte_address_bit;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
  } emb_pins_t;
  // ========================================
  // Whole state of the top module
  typedef struct packed {
    emb_state_t state;
    emb_req_t req;
    logic [7:0] hold;
    logic [3:0] wcnt;
    logic [7:0] ctrl;
    logic [7:0] pad;
    logic [7:0] pmd;
    logic [15:0] rdata;
    emb_pins_t pins;
    logic req_ready;
    logic rsp_valid;
    logic gpio_mode;
    logic [2:0] pullup_en;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } emb_st_t;
  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } emb_div_t;
endpackage

/* File: core/emb_tick_div.sv */
// Bus phase tick divider for the selected core clock rate
`timescale 1ns/1ps
module emb_tick_div (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Rate select, tick every 2**sel clocks
  input wire logic [1:0] sel,
  output logic tick
);
  emb_pkg::emb_div_t st;
  emb_pkg::emb_div_t nx;
  logic [2:0] limit;

  // ========================================
  // Divider
  always_comb
  begin
    limit = 3'((4'h1 << sel) - 4'h1);
    nx = st;
    nx.tick = 1'b0;
    if (st.cnt >= limit)
    begin
      nx.cnt = 3'h0;
      nx.tick = 1'b1;
    end
    else
    begin
      nx.cnt = st.cnt + 3'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign tick = st.tick;
endmodule

/* File: core/emb_seq.sv */
// External memory bus sequencer with APB register file
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "emb_params.svh"
module emb_seq (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Configuration and power state
  input wire logic bus_width_8,
  input wire logic wait_cfg_en,
  input wire logic [1:0] clk_slow_sel,
  input wire logic power_sleep,
  input wire logic power_idle,
  // Core request and answer
  input wire logic req_valid,
  input wire emb_pkg::emb_req_t req_in,
  output logic req_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  // External bus pins
  input wire logic [15:0] ad_in,
  output emb_pkg::emb_pins_t pins,
  output logic gpio_mode,
  output logic [2:0] pullup_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  localparam emb_pkg::emb_pins_t PIN_IDLE = '{ad_out: 16'h0000, ad_oe: 2'b00,
    addr_upper: 4'h0, ale: 1'b0, oe_n: 1'b1, ce_n: 1'b1, write_high_strobe_n: 1'b1,
    write_low_strobe_n: 1'b1, byte_address_bit: 1'b0, upper_byte_select_n: 1'b1,
    lower_byte_select_n: 1'b1};

  emb_pkg::emb_st_t st;
  emb_pkg::emb_st_t nx;
  logic [1:0] rst_ff;
  logic rst_sync_n;
  logic tick;
  logic pd;
  logic bus_off;
  logic ext_bus_disable;
  logic [1:0] delay_cycles;
  logic [1:0] write_mode;
  logic is_read;
  logic is_table;
  logic word_even;
  logic [31:0] rd_mux;
  logic unmapped;

  // ========================================
  // Reset release
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_ff <= 2'b00;
    else
      rst_ff <= {rst_ff[0], 1'b1};
  end
  assign rst_sync_n = rst_ff[1];
  // Slower run clocks only stretch the tick, so wait states scale too
  emb_tick_div u_div (
    .core_clk(core_clk),
    .rst_n(rst_sync_n),
    .sel(clk_slow_sel),
    .tick(tick)
  );

  // ========================================
  // Decoded fields
  assign pd = power_sleep | power_idle;
  assign bus_off = st.pmd[`EMB_PMD_BUS_BIT];
  assign ext_bus_disable = st.ctrl[`EMB_CTRL_DIS_BIT];
  assign delay_cycles = st.ctrl[`EMB_CTRL_WAIT_HI:`EMB_CTRL_WAIT_LO];
  assign write_mode = st.ctrl[`EMB_CTRL_WM_HI:`EMB_CTRL_WM_LO];
  assign is_read = st.req.kind != emb_pkg::EMB_TABLE_WRITE_OP;
  assign is_table = st.req.kind != emb_pkg::EMB_FETCH;
  assign word_even = req_in.kind == emb_pkg::EMB_TABLE_WRITE_OP && !bus_width_8 &&
    write_mode[1] && !req_in.table_pointer[0];

  // ========================================
  // Pin levels for a given state
  function automatic emb_pkg::emb_pins_t drive_pins(input emb_pkg::emb_state_t s,
    input emb_pkg::emb_req_t r, input logic [7:0] hold, input logic m8,
    input logic [1:0] wm);
    emb_pkg::emb_pins_t p;
    logic lsb;
    logic wr;
    p = PIN_IDLE;
    lsb = r.table_pointer[0];
    wr = r.kind == emb_pkg::EMB_TABLE_WRITE_OP;
    if (s != emb_pkg::ST_IDLE)
    begin
      p.ce_n = 1'b0;
      p.addr_upper = r.table_pointer[20:17];
      p.byte_address_bit = wr & lsb;
      p.upper_byte_select_n = 1'b0;
      p.lower_byte_select_n = 1'b0;
    end
    case (s)
      emb_pkg::ST_ADDR:
      begin
        p.ale = 1'b1;
        p.ad_out = r.table_pointer[16:1];
        p.ad_oe = 2'b11;
      end
      emb_pkg::ST_DATA, emb_pkg::ST_DATA2:
      begin
        if (!wr)
        begin
          // Eight bit width: second byte follows with byte bit set
          p.oe_n = 1'b0;
          p.byte_address_bit = m8 && s == emb_pkg::ST_DATA2;
        end
        else
        begin
          p.ad_out = {r.table_latch_reg, r.table_latch_reg};
          p.ad_oe = 2'b11;
          if (m8)
            p.write_low_strobe_n = 1'b0;
          else if (wm[1] && lsb)
          begin
            p.ad_out = {r.table_latch_reg, hold};
            p.write_high_strobe_n = 1'b0;
          end
          else if (wm[1])
            p.ad_oe = 2'b00;
          else
          begin
            p.upper_byte_select_n = !lsb;
            p.lower_byte_select_n = lsb;
            if (wm == `EMB_WM_BYTE_WRITE && !lsb)
              p.write_low_strobe_n = 1'b0;
            else
              p.write_high_strobe_n = 1'b0;
          end
        end
      end
      default: ;
    endcase
    return p;
  endfunction
  // ========================================
  // Register read mux
  always_comb
  begin
    unmapped = 1'b0;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `EMB_OFS_CTRL: rd_mux = {24'h000000, st.ctrl};
      `EMB_OFS_PAD: rd_mux = {24'h000000, st.pad};
      `EMB_OFS_PMD: rd_mux = {24'h000000, st.pmd};
      `EMB_OFS_STAT: rd_mux = {16'h0000, st.hold, 5'h00, pd, st.gpio_mode,
        st.state != emb_pkg::ST_IDLE};
      default: unmapped = 1'b1;
    endcase
  end

  // ========================================
  // Next state
  always_comb
  begin
    nx = st;
    nx.rsp_valid = 1'b0;
    nx.pready = 1'b0;
    nx.pslverr = 1'b0;
    if (psel && !penable)
    begin
      nx.pready = 1'b1;
      nx.prdata = rd_mux;
      nx.pslverr = unmapped;
    end
    if (psel && penable && st.pready && pwrite && pstrb[0])
      case (paddr)
        `EMB_OFS_CTRL: nx.ctrl = pwdata[7:0] & `EMB_CTRL_WMASK;
        `EMB_OFS_PAD: nx.pad = pwdata[7:0] & `EMB_PAD_WMASK;
        `EMB_OFS_PMD: nx.pmd = pwdata[7:0];
        default: ;
      endcase
    if (!pd)
    begin
      case (st.state)
        emb_pkg::ST_IDLE:
          if (req_valid && st.req_ready)
          begin
            nx.req = req_in;
            nx.state = emb_pkg::ST_ADDR;
            if (word_even)
              nx.hold = req_in.table_latch_reg;
          end
        emb_pkg::ST_ADDR:
          if (tick)
            nx.state = emb_pkg::ST_DATA;
        emb_pkg::ST_DATA:
          if (tick)
          begin
            nx.state = emb_pkg::ST_DATA2;
            if (bus_width_8)
              nx.rdata[7:0] = ad_in[7:0];
          end
        emb_pkg::ST_DATA2:
          if (tick)
          begin
            nx.state = emb_pkg::ST_END;
            nx.rdata = bus_width_8 ? {ad_in[7:0], st.rdata[7:0]} : ad_in;
            nx.rsp_valid = 1'b1;
          end
        emb_pkg::ST_END:
          if (tick && is_table && wait_cfg_en && delay_cycles != 2'b00)
          begin
            nx.state = emb_pkg::ST_WAIT;
            nx.wcnt = 4'(delay_cycles * `EMB_TICKS_PER_TCY) - 4'h1;
          end
          else if (tick)
            nx.state = emb_pkg::ST_IDLE;
        emb_pkg::ST_WAIT:
          if (tick && st.wcnt == 4'h0)
            nx.state = emb_pkg::ST_IDLE;
          else if (tick)
            nx.wcnt = st.wcnt - 4'h1;
        default: nx.state = emb_pkg::ST_IDLE;
      endcase
      nx.pins = drive_pins(nx.state, nx.req, nx.hold, bus_width_8, write_mode);
    end
    else
    begin
      // Frozen, only chip enable and the byte selects are parked inactive
      nx.pins.ce_n = 1'b1;
      nx.pins.upper_byte_select_n = 1'b1;
      nx.pins.lower_byte_select_n = 1'b1;
    end
    nx.req_ready = nx.state == emb_pkg::ST_IDLE && !pd && !bus_off;
    nx.gpio_mode = nx.state == emb_pkg::ST_IDLE && (ext_bus_disable || bus_off);
    nx.pullup_en = nx.pad[`EMB_PAD_PU_HI:`EMB_PAD_PU_LO];
  end

  always_ff @(posedge core_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st <= '0;
      st.state <= emb_pkg::ST_IDLE;
      st.ctrl <= `EMB_CTRL_RESET;
      st.pad <= `EMB_PAD_RESET;
      st.pmd <= `EMB_PMD_RESET;
      st.pins <= PIN_IDLE;
    end
    else
      st <= nx;
  end
  // ========================================
  // Outputs
  assign req_ready = st.req_ready;
  assign rsp_valid = st.rsp_valid;
  assign rsp_data = st.rdata;
  assign pins = st.pins;
  assign gpio_mode = st.gpio_mode;
  assign pullup_en = st.pullup_en;
  assign pready = st.pready;
  assign prdata = st.prdata;
  assign pslverr = st.pslverr;

  // ========================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_sync_n);
  logic wr_now;
  logic data_now;
  // Parked chip enable marks pins still frozen from a suspend
  assign wr_now = st.req.kind == emb_pkg::EMB_TABLE_WRITE_OP && !bus_width_8;
  assign data_now = st.state == emb_pkg::ST_DATA && !pd && !st.pins.ce_n;
  sequence s_second_byte;
    st.pins.byte_address_bit && !st.pins.oe_n;
  endsequence
  sequence s_parked;
    st.pins.ce_n && st.pins.upper_byte_select_n && st.pins.lower_byte_select_n;
  endsequence
  property p_byte_write;
    data_now && wr_now && write_mode == 2'b00 |->
      st.pins.ad_out[15:8] == st.pins.ad_out[7:0] &&
      st.pins.write_high_strobe_n == !st.req.table_pointer[0] &&
      st.pins.write_low_strobe_n == st.req.table_pointer[0];
  endproperty
  a_byte_write: assert property (p_byte_write)
    else $error("byte write strobe or data wrong");
  property p_word_even;
    data_now && wr_now && write_mode[1] && !st.req.table_pointer[0] |->
      st.pins.ad_oe == 2'b00 && st.pins.write_high_strobe_n && st.pins.write_low_strobe_n &&
      st.hold == st.req.table_latch_reg;
  endproperty
  a_word_even: assert property (p_word_even)
    else $error("even word write drove bus or strobed");
  property p_word_odd;
    data_now && wr_now && write_mode[1] && st.req.table_pointer[0] |->
      st.pins.ad_out == {st.req.table_latch_reg, st.hold} && st.pins.ad_oe == 2'b11;
  endproperty
  a_word_odd: assert property (p_word_odd)
    else $error("odd word write data wrong");
  property p_word_ctl;
    data_now && wr_now && write_mode[1] |-> st.pins.write_low_strobe_n &&
      !st.pins.upper_byte_select_n && !st.pins.lower_byte_select_n &&
      st.pins.byte_address_bit == st.req.table_pointer[0];
  endproperty
  a_word_ctl: assert property (p_word_ctl)
    else $error("word write controls wrong");
  property p_byte_select;
    data_now && wr_now && write_mode == 2'b01 |-> !st.pins.write_high_strobe_n &&
      st.pins.write_low_strobe_n &&
      st.pins.lower_byte_select_n == st.req.table_pointer[0];
  endproperty
  a_byte_select: assert property (p_byte_select)
    else $error("byte select write controls wrong");
  property p_two_bytes;
    $rose(st.state == emb_pkg::ST_DATA2) && bus_width_8 && is_read && !pd && !$past(pd) |->
      s_second_byte and $past(!st.pins.byte_address_bit && !st.pins.oe_n);
  endproperty
  a_two_bytes: assert property (p_two_bytes)
    else $error("eight bit fetch did not toggle byte bit");
  property p_ale;
    $rose(st.state == emb_pkg::ST_ADDR) |-> st.pins.ale && st.pins.ad_oe == 2'b11 &&
      st.pins.ad_out == st.req.table_pointer[16:1];
  endproperty
  a_ale: assert property (p_ale)
    else $error("address latch strobe missing");
  property p_ce;
    !pd && !$past(pd) && st.state != emb_pkg::ST_IDLE |-> !st.pins.ce_n;
  endproperty
  a_ce: assert property (p_ce)
    else $error("chip enable not low during access");
  property p_freeze;
    pd |=> s_parked ##0 (st.state == $past(st.state) &&
      st.pins.ad_out == $past(st.pins.ad_out));
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("bus not frozen in sleep or idle");
  property p_zero_bits;
    pready && !pslverr && paddr == `EMB_OFS_CTRL |-> prdata[6] == 1'b0 &&
      prdata[3:2] == 2'b00 && prdata[31:8] == 24'h000000;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unimplemented bits read nonzero");
endmodule

/* File: dv/emb_mem_model.sv */
// Behavioural external SRAM or byte-wide memory on the multiplexed bus
`timescale 1ns/1ps
module emb_mem_model (
  // Clock
  input wire logic core_clk,
  // Bus from the sequencer
  input wire emb_pkg::emb_pins_t pins,
  input wire logic m8,
  // Data back to the sequencer
  output logic [15:0] ad_in
);
  // ========================================
  // Storage and address latch
  logic [7:0] mem [0:511];
  logic [7:0] addr;
  logic [15:0] last;
  logic rd;
  initial
  begin
    for (int i = 0; i < 512; i++)
      mem[i] = i[7:0] ^ 8'h55;
    addr = 8'h00;
    last = 16'h0000;
  end
  // ========================================
  // Writes on any strobe, bytes picked by the selects, or by the byte bit at eight bit width
  always @(posedge core_clk)
  begin
    last <= ad_in;
    if (pins.ale)
      addr <= pins.ad_out[7:0];
    if (!pins.ce_n && !(pins.write_high_strobe_n && pins.write_low_strobe_n))
    begin
      if (m8)
        mem[{addr, pins.byte_address_bit}] <= pins.ad_out[7:0];
      else
      begin
        if (!pins.upper_byte_select_n)
          mem[{addr, 1'b1}] <= pins.ad_out[15:8];
        if (!pins.lower_byte_select_n)
          mem[{addr, 1'b0}] <= pins.ad_out[7:0];
      end
    end
  end
  // ========================================
  // Reads; released lines show the inverse of the last level
  assign rd = !pins.oe_n && !pins.ce_n;
  always_comb
    if (!rd)
      ad_in = ~last;
    else if (m8)
      ad_in = {~last[15:8], mem[{addr, pins.byte_address_bit}]};
    else
      ad_in = {mem[{addr, 1'b1}], mem[{addr, 1'b0}]};
endmodule

/* File: dv/ext_memory_bus_modes_tb.sv */
// Self-checking bench of the external memory bus sequencer
`timescale 1ns/1ps
`include "emb_params.svh"
module ext_memory_bus_modes_tb;
  // ========================================
  // Design ports
  logic core_clk, rst_n, bus_width_8, wait_cfg_en, power_sleep, power_idle, req_valid;
  logic [1:0] clk_slow_sel;
  emb_pkg::emb_req_t req_in;
  logic req_ready, rsp_valid, gpio_mode, psel, penable, pwrite, pready, pslverr;
  logic [15:0] rsp_data, ad_in;
  emb_pkg::emb_pins_t pins;
  logic [2:0] pullup_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  // ========================================
  // Bench state
  int failures, total_checks, wh_cnt, wl_cnt, ale_cnt, bad_ce, drv_seen, lat, tail;
  logic [15:0] wh_dat, wl_dat, rd_word;
  logic [2:0] sel_at;
  logic gm_ale, err;
  emb_seq emb_seq_inst (.core_clk(core_clk), .rst_n(rst_n), .bus_width_8(bus_width_8),
    .wait_cfg_en(wait_cfg_en), .clk_slow_sel(clk_slow_sel), .power_sleep(power_sleep),
    .power_idle(power_idle), .req_valid(req_valid), .req_in(req_in), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ad_in(ad_in), .pins(pins),
    .gpio_mode(gpio_mode), .pullup_en(pullup_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  emb_mem_model emb_mem_model_inst (.core_clk(core_clk), .pins(pins), .m8(bus_width_8),
    .ad_in(ad_in));
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // ========================================
  // Mid-cycle pin monitor, so no race with the tasks
  always @(negedge core_clk)
  begin
    if (!pins.write_high_strobe_n)
    begin
      wh_cnt++;
      wh_dat = pins.ad_out;
      sel_at = {pins.byte_address_bit, pins.upper_byte_select_n, pins.lower_byte_select_n};
    end
    if (!pins.write_low_strobe_n)
    begin
      wl_cnt++;
      wl_dat = pins.ad_out;
      sel_at = {pins.byte_address_bit, pins.upper_byte_select_n, pins.lower_byte_select_n};
    end
    if (pins.ale)
    begin
      ale_cnt++;
      gm_ale = gpio_mode;
    end
    if (pins.ce_n && !(pins.oe_n && pins.write_high_strobe_n && pins.write_low_strobe_n))
      bad_ce++;
    if (!pins.ce_n && !pins.ale && pins.ad_oe != 2'b00)
      drv_seen++;
  end
  // ========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      failures++;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic req(input emb_pkg::emb_kind_t k, input logic [20:0] p, input logic [7:0] b);
    @(posedge core_clk);
    {wh_cnt, wl_cnt, ale_cnt, bad_ce, drv_seen} = '0;
    req_in <= '{kind: k, table_pointer: p, table_latch_reg: b};
    req_valid <= 1'b1;
    lat = 0;
    do
    begin
      @(posedge core_clk);
      lat++;
    end
    while (req_ready !== 1'b1 && lat < 200);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge core_clk);
      lat++;
    end
    while (rsp_valid !== 1'b1 && lat < 200);
    rd_word = rsp_data;
    tail = 0;
    do
    begin
      @(posedge core_clk);
      tail++;
    end
    while (req_ready !== 1'b1 && tail < 200);
    if (lat >= 200 || tail >= 200)
      failures++;
  endtask
  task automatic wr(input logic [20:0] p, input logic [7:0] b);
    req(emb_pkg::EMB_TABLE_WRITE_OP, p, b);
  endtask
  task automatic rdw(input logic [20:0] p);
    req(emb_pkg::EMB_TABLE_READ, p, 8'h00);
  endtask
  task automatic test_done();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ========================================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #300000;
    failures++;
    test_done();
  end
  // ========================================
  // Tests
  initial
  begin
    int t0;
    int lat0;
    emb_pkg::emb_pins_t snap;
    {failures, total_checks, wh_cnt, wl_cnt, ale_cnt, bad_ce, drv_seen} = '0;
    {rst_n, bus_width_8, wait_cfg_en, power_sleep, power_idle, req_valid} = '0;
    {psel, penable, pwrite, clk_slow_sel, paddr, pwdata} = '0;
    req_in = '0;
    pstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    rchk(`EMB_OFS_CTRL, 32'h30);
    rchk(`EMB_OFS_PAD, 32'h00);
    apb(1'b1, `EMB_OFS_CTRL, 32'hffff_ffff);
    rchk(`EMB_OFS_CTRL, 32'hb3);
    apb(1'b1, `EMB_OFS_PAD, 32'hffff_ffff);
    rchk(`EMB_OFS_PAD, 32'he6);
    chk(pullup_en, 32'h7);
    pstrb <= 4'h0;
    apb(1'b1, `EMB_OFS_PAD, 32'h00);
    pstrb <= 4'hf;
    rchk(`EMB_OFS_PAD, 32'he6);
    apb(1'b1, `EMB_OFS_PMD, 32'hff);
    rchk(`EMB_OFS_PMD, 32'hff);
    apb(1'b1, `EMB_OFS_PMD, 32'h00);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd[30:0]}, {1'b1, 31'h0});
    $display("test registers done");
    apb(1'b1, `EMB_OFS_CTRL, 32'h00);
    wr(21'h20, 8'h5a);
    chk(wl_dat, 32'h5a5a);
    chk(wh_cnt, 32'h0);
    chk(ale_cnt, 32'h1);
    chk(bad_ce, 32'h0);
    wr(21'h21, 8'ha5);
    chk(wh_dat, 32'ha5a5);
    chk(wl_cnt, 32'h0);
    rdw(21'h20);
    chk(rd_word, 32'ha55a);
    $display("test byte write done");
    for (int m = 2; m < 4; m++)
    begin
      apb(1'b1, `EMB_OFS_CTRL, m);
      wr(21'h40, 8'h11 * m);
      chk(wh_cnt + wl_cnt, 32'h0);
      chk(drv_seen, 32'h0);
      rchk(`EMB_OFS_STAT, {8'(8'h11 * m), 8'h00});
      wr(21'h41, 8'h22 * m);
      chk(wh_dat, {8'(8'h22 * m), 8'(8'h11 * m)});
      chk({wl_cnt, sel_at}, {32'h0, 3'b100});
      rdw(21'h40);
      chk(rd_word, {8'(8'h22 * m), 8'(8'h11 * m)});
    end
    $display("test word write done");
    apb(1'b1, `EMB_OFS_CTRL, 32'h01);
    wr(21'h61, 8'h77);
    chk(wh_dat, 32'h7777);
    chk({wl_cnt, sel_at}, {32'h0, 3'b101});
    rdw(21'h60);
    chk(rd_word, 32'h7735);
    $display("test byte select done");
    apb(1'b1, `EMB_OFS_CTRL, 32'h00);
    bus_width_8 <= 1'b1;
    wr(21'ha0, 8'h3c);
    chk({wl_dat, sel_at[2]}, {16'h3c3c, 1'b0});
    wr(21'ha1, 8'hc3);
    chk({wl_dat, sel_at[2]}, {16'hc3c3, 1'b1});
    rdw(21'ha0);
    chk(rd_word, 32'hc33c);
    bus_width_8 <= 1'b0;
    $display("test eight bit done");
    wait_cfg_en <= 1'b1;
    rdw(21'h20);
    t0 = tail;
    lat0 = lat;
    for (int d = 1; d < 4; d++)
    begin
      apb(1'b1, `EMB_OFS_CTRL, d << 4);
      rdw(21'h20);
      chk(tail - t0, d * 4);
    end
    req(emb_pkg::EMB_FETCH, 21'h20, 8'h00);
    chk(tail, t0);
    wait_cfg_en <= 1'b0;
    rdw(21'h20);
    chk(tail, t0);
    wait_cfg_en <= 1'b1;
    apb(1'b1, `EMB_OFS_CTRL, 32'h10);
    clk_slow_sel <= 2'b01;
    rdw(21'h20);
    chk({rd_word, lat > lat0, tail > t0 + 4}, {16'ha55a, 2'b11});
    clk_slow_sel <= 2'b00;
    wait_cfg_en <= 1'b0;
    $display("test wait states done");
    for (int s = 0; s < 2; s++)
    begin
      fork
        rdw(21'h40);
        begin
          repeat (3) @(posedge core_clk);
          power_sleep <= (s == 0);
          power_idle <= (s == 1);
          repeat (2) @(posedge core_clk);
          snap = pins;
          repeat (5) @(posedge core_clk);
          chk(pins, snap);
          chk({snap.ce_n, snap.upper_byte_select_n, snap.lower_byte_select_n}, 32'h7);
          power_sleep <= 1'b0;
          power_idle <= 1'b0;
        end
      join
      chk(rd_word, 32'h6633);
    end
    $display("test power modes done");
    apb(1'b1, `EMB_OFS_CTRL, 32'h80);
    repeat (2) @(posedge core_clk);
    chk(gpio_mode, 32'h1);
    rdw(21'h20);
    chk({gm_ale, rd_word}, {1'b0, 16'ha55a});
    repeat (2) @(posedge core_clk);
    chk(gpio_mode, 32'h1);
    $display("test bus disable done");
    test_done();
  end
endmodule
